// ==== rtl/nbt_bank.sv ====
// register bank for bar2/bar3 setup and bar2 address translation
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module nbt_bank
	import nbt_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	output logic [63:0] o_bar2_xlat_base,
	output logic o_bar2_pair64,
	output logic [63:0] o_bar2_base,
	output logic [31:0] o_bar3_base
);
	nbt_bus_if bus();
	logic [31:0] bar1_tbase_q; // upper translated half for 64-bit mode
	logic [31:0] bar2_setup_q; // bar2 setup
	logic [31:0] bar2_tbase_q; // bar2 translated base
	logic [31:0] bar3_setup_q; // bar3 setup
	logic [31:0] bar2_base_q; // bar2 base address field
	logic [31:0] bar3_base_q; // bar3 base, or bar2 upper when paired
	logic pair64; // bar2 in 64-bit memory pairing
	logic [31:0] rd_d; // read mux
	logic [31:0] bar3_setup_wr; // bar3 write value after legalising

	// bus front end
	nbt_ahb_slave u_slave (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_hsel(i_hsel),
		.i_haddr(i_haddr),
		.i_htrans(i_htrans),
		.i_hwrite(i_hwrite),
		.i_hsize(i_hsize),
		.i_hwdata(i_hwdata),
		.i_hready(i_hready),
		.o_hreadyout(o_hreadyout),
		.o_hrdata(o_hrdata),
		.bus(bus)
	);

	// decoded write strobe, used by every register
	function automatic logic wr_hit(input logic wr, input logic [11:0] a, input logic [11:0] off);
		wr_hit = wr && (a == off);
	endfunction

	// base field mask: size 0 passes bits 31:4, below four disables the bar
	function automatic logic [31:0] base_mask(input logic [5:0] size);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (size == 6'h00)
			m = 32'hffff_fff0;
		else if (size >= NBT_SIZE_MIN)
			m = (size >= 6'h20) ? 32'h0000_0000 : (32'hffff_ffff << size[4:0]);
		base_mask = m;
	endfunction

	// pairing mode: bar2 memory space with 64-bit type
	assign pair64 = !bar2_setup_q[NBT_SPACE_BIT] && (bar2_setup_q[2:1] == NBT_TYPE_ADDR64);

	// bar3 setup legalising: io forces type zero, reserved type codes kept out
	always_comb
	begin
		bar3_setup_wr = bus.wdata & NBT_SETUP_MASK;
		if (bar3_setup_wr[NBT_SPACE_BIT] || (bar3_setup_wr[2:1] != NBT_TYPE_ADDR32))
			bar3_setup_wr[2:1] = NBT_TYPE_ADDR32;
	end

	// setup and translation registers; only i_rst (the non-sticky reset source) clears them,
	// fundamental and hot resets are not wired here so the settings survive them
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			bar1_tbase_q <= NBT_RST_VAL;
			bar2_setup_q <= NBT_RST_VAL;
			bar2_tbase_q <= NBT_RST_VAL;
			bar3_setup_q <= NBT_RST_VAL;
		end
		else
		begin
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR1_TBASE))
				bar1_tbase_q <= bus.wdata;
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR2_SETUP))
				bar2_setup_q <= bus.wdata & NBT_SETUP_MASK;
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR2_TBASE))
				bar2_tbase_q <= bus.wdata & NBT_TBASE_MASK;
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR3_SETUP) && !pair64)
				bar3_setup_q <= bar3_setup_wr;
		end
	end

	// bar base fields, masked by the size codes; bar3 is stored unmasked while paired
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			bar2_base_q <= NBT_RST_VAL;
			bar3_base_q <= NBT_RST_VAL;
		end
		else
		begin
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR2_BASE))
				bar2_base_q <= bus.wdata & base_mask(bar2_setup_q[9:4]);
			if (wr_hit(bus.wr, bus.addr, NBT_OFF_BAR3_BASE))
				bar3_base_q <= pair64 ? bus.wdata : (bus.wdata & base_mask(bar3_setup_q[9:4]));
		end
	end

	// read mux; bar bases read zero while disabled
	always_comb
	begin
		rd_d = 32'h0000_0000;
		case (bus.addr)
			NBT_OFF_BAR1_TBASE: rd_d = bar1_tbase_q;
			NBT_OFF_BAR2_SETUP: rd_d = bar2_setup_q;
			NBT_OFF_BAR2_TBASE: rd_d = bar2_tbase_q & NBT_TBASE_MASK;
			NBT_OFF_BAR3_SETUP: rd_d = pair64 ? 32'h0000_0000 : bar3_setup_q;
			NBT_OFF_BAR2_BASE:
				rd_d = bar2_setup_q[NBT_EN_BIT] ?
					((bar2_base_q & base_mask(bar2_setup_q[9:4])) | {28'h0000000, bar2_setup_q[3:0]}) :
					32'h0000_0000;
			NBT_OFF_BAR3_BASE:
				if (pair64)
					rd_d = bar2_setup_q[NBT_EN_BIT] ? bar3_base_q : 32'h0000_0000;
				else if (bar3_setup_q[NBT_EN_BIT])
					rd_d = (bar3_base_q & base_mask(bar3_setup_q[9:4]))
						| {28'h0000000, bar3_setup_q[NBT_PREFETCH_SELECT_BIT], bar3_setup_q[2:1], bar3_setup_q[NBT_SPACE_BIT]};
			default: rd_d = 32'h0000_0000; // unmapped reads zero
		endcase
	end
	assign bus.rdata = rd_d;

	// outputs to the translation datapath, registered
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_bar2_xlat_base <= 64'h0000_0000_0000_0000;
			o_bar2_pair64 <= 1'b0;
			o_bar2_base <= 64'h0000_0000_0000_0000;
			o_bar3_base <= 32'h0000_0000;
		end
		else
		begin
			o_bar2_pair64 <= pair64;
			o_bar2_xlat_base <= {(pair64 ? bar1_tbase_q : 32'h0000_0000), bar2_tbase_q & NBT_TBASE_MASK};
			o_bar2_base <= bar2_setup_q[NBT_EN_BIT] ?
				{(pair64 ? bar3_base_q : 32'h0000_0000), bar2_base_q & base_mask(bar2_setup_q[9:4])} :
				64'h0000_0000_0000_0000;
			o_bar3_base <= (!pair64 && bar3_setup_q[NBT_EN_BIT]) ? (bar3_base_q & base_mask(bar3_setup_q[9:4])) :
				32'h0000_0000;
		end
	end

	// assertions
	a_bar3_ro_pair: assert property (@(posedge i_mclk) disable iff (i_rst)
		pair64 && (bus.addr == NBT_OFF_BAR3_SETUP) |-> bus.rdata == 32'h0000_0000)
		else $error("bar3 setup not zero in pairing mode");
	a_bar3_hold_pair: assert property (@(posedge i_mclk) disable iff (i_rst)
		pair64 && wr_hit(bus.wr, bus.addr, NBT_OFF_BAR3_SETUP) |=> $stable(bar3_setup_q))
		else $error("bar3 setup changed in pairing mode");
	a_io_type_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
		bar3_setup_q[NBT_SPACE_BIT] |-> bar3_setup_q[2:1] == 2'h0)
		else $error("bar3 io with nonzero type");
	a_type_legal: assert property (@(posedge i_mclk) disable iff (i_rst)
		bar3_setup_q[2:1] == NBT_TYPE_ADDR32)
		else $error("bar3 reserved type held");
	a_tbase_low_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
		bar2_tbase_q[3:0] == 4'h0)
		else $error("translated base low bits set");
	a_disabled_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
		!bar2_setup_q[NBT_EN_BIT] |=> o_bar2_base == 64'h0000_0000_0000_0000)
		else $error("disabled bar2 not zero");
	a_xlat_upper: assert property (@(posedge i_mclk) disable iff (i_rst)
		pair64 |=> o_bar2_xlat_base[63:32] == $past(bar1_tbase_q))
		else $error("translated upper half wrong");
	a_setup_resv: assert property (@(posedge i_mclk) disable iff (i_rst)
		(bar2_setup_q & ~NBT_SETUP_MASK) == 32'h0000_0000)
		else $error("reserved setup bits set");
	a_small_size: assert property (@(posedge i_mclk) disable iff (i_rst)
		(bar2_setup_q[9:4] != 6'h00) && (bar2_setup_q[9:4] < NBT_SIZE_MIN) |=> o_bar2_base[31:0] == 32'h0000_0000)
		else $error("small size did not disable base");
	a_bar3_space_rd: assert property (@(posedge i_mclk) disable iff (i_rst)
		!pair64 && bar3_setup_q[NBT_EN_BIT] && (bus.addr == NBT_OFF_BAR3_BASE)
		|-> bus.rdata[0] == bar3_setup_q[NBT_SPACE_BIT] && bus.rdata[3] == bar3_setup_q[NBT_PREFETCH_SELECT_BIT])
		else $error("bar3 reported space or prefetch wrong");
endmodule
`default_nettype wire

// ==== rtl/nbt_pkg.sv ====
// package of offsets, field layouts and reset values for the bar2/bar3 setup bank
package nbt_pkg;
	// register byte offsets
	localparam logic [11:0] NBT_OFF_BAR1_TBASE = 12'h080;
	localparam logic [11:0] NBT_OFF_BAR2_SETUP = 12'h088;
	localparam logic [11:0] NBT_OFF_BAR2_TBASE = 12'h090;
	localparam logic [11:0] NBT_OFF_BAR3_SETUP = 12'h094;
	localparam logic [11:0] NBT_OFF_BAR2_BASE = 12'h098;
	localparam logic [11:0] NBT_OFF_BAR3_BASE = 12'h09c;
	// field positions
	localparam int NBT_EN_BIT = 31;
	localparam int NBT_SPACE_BIT = 0;
	localparam int NBT_TYPE_LO = 1;
	localparam int NBT_PREFETCH_SELECT_BIT = 3;
	localparam int NBT_SIZE_LO = 4;
	// setup writable mask: enable, size, prefetch, type, space
	localparam logic [31:0] NBT_SETUP_MASK = 32'h8000_03ff;
	// translated base writable mask, bits 3:0 reserved
	localparam logic [31:0] NBT_TBASE_MASK = 32'hffff_fff0;
	// address type codes
	localparam logic [1:0] NBT_TYPE_ADDR32 = 2'h0;
	localparam logic [1:0] NBT_TYPE_ADDR64 = 2'h2;
	// smallest nonzero size code that enables a bar
	localparam logic [5:0] NBT_SIZE_MIN = 6'h04;
	// reset values
	localparam logic [31:0] NBT_RST_VAL = 32'h0000_0000;
endpackage

// ==== rtl/nbt_bus_if.sv ====
// interface carrying decoded register accesses from the bus slave to the bank
`timescale 1ns/1ps
`default_nettype none
interface nbt_bus_if;
	logic wr; // one-cycle write strobe
	logic [11:0] addr; // byte offset of access
	logic [31:0] wdata; // write data
	logic [31:0] rdata; // read data from bank
	modport slave (output wr, output addr, output wdata, input rdata);
	modport bank (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtl/nbt_ahb_slave.sv ====
// ahb-lite slave front end: one wait state, always okay
`timescale 1ns/1ps
`default_nettype none
module nbt_ahb_slave
	import nbt_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [31:0] o_hrdata,
	nbt_bus_if.slave bus
);
	// states of the data phase
	typedef enum logic [1:0] {NBT_IDLE = 2'b00, NBT_WAIT = 2'b01, NBT_DONE = 2'b11} nbt_state_t;
	nbt_state_t state_q;
	logic write_q; // latched direction
	logic [11:0] addr_q; // latched offset
	logic take; // address phase accepted
	assign take = i_hsel && i_hready && i_htrans[1];
	// only single whole-word transfers are used, so hsize is not checked
	// state register
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
			state_q <= NBT_IDLE;
		else
			case (state_q)
				NBT_IDLE: if (take) state_q <= NBT_WAIT;
				NBT_WAIT: state_q <= NBT_DONE;
				NBT_DONE: state_q <= take ? NBT_WAIT : NBT_IDLE;
				default: state_q <= NBT_IDLE;
			endcase
	end
	// latch address phase
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			write_q <= 1'b0;
			addr_q <= 12'h000;
		end
		else if (take)
		begin
			write_q <= i_hwrite;
			addr_q <= i_haddr[11:0];
		end
	end
	// hreadyout low in the wait cycle, read data captured there
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_hreadyout <= 1'b1;
			o_hrdata <= 32'h0000_0000;
		end
		else
		begin
			o_hreadyout <= (state_q == NBT_WAIT) || !(take);
			if (state_q == NBT_WAIT)
				o_hrdata <= write_q ? 32'h0000_0000 : bus.rdata;
		end
	end
	// write strobe in the wait cycle, hwdata is stable there
	assign bus.wr = (state_q == NBT_WAIT) && write_q;
	assign bus.addr = addr_q;
	assign bus.wdata = i_hwdata;
endmodule
`default_nettype wire

// ==== sim/nbt_bank_tb.sv ====
// self-checking testbench for the bar2/bar3 setup and translation bank
`timescale 1ns/1ps
`default_nettype none
module nbt_bank_tb
	import nbt_pkg::*;
;
	logic i_mclk = 1'b0; // 125 MHz bench clock
	logic i_rst = 1'b1; // synchronous reset, held at start
	logic i_hsel = 1'b0;
	logic [31:0] i_haddr = 32'h0;
	logic [1:0] i_htrans = 2'h0;
	logic i_hwrite = 1'b0;
	logic [2:0] i_hsize = 3'h0; // word size, driven with each address phase
	logic [31:0] i_hwdata = 32'h0;
	logic o_hreadyout;
	logic [31:0] o_hrdata;
	logic [63:0] o_bar2_xlat_base;
	logic o_bar2_pair64;
	logic [63:0] o_bar2_base;
	logic [31:0] o_bar3_base;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h0000_001c; // xorshift state, fixed start
	logic [31:0] rd, tb1, tb2, b3, v; // read data and remembered values
	logic [11:0] offs [7] = '{NBT_OFF_BAR1_TBASE, NBT_OFF_BAR2_SETUP, NBT_OFF_BAR2_TBASE, NBT_OFF_BAR3_SETUP,
		NBT_OFF_BAR2_BASE, NBT_OFF_BAR3_BASE, 12'h0a0};

	// word transfers only; hready loops back from the single slave
	nbt_bank dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
		.i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_bar2_xlat_base(o_bar2_xlat_base),
		.o_bar2_pair64(o_bar2_pair64), .o_bar2_base(o_bar2_base), .o_bar3_base(o_bar3_base));

	// free-running clock, 8 ns period
	initial forever #4 i_mclk = ~i_mclk;

	// xorshift source, repeatable from its fixed start
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// bar3 setup readback: type always stored as zero, reserved codes dropped
	function automatic logic [31:0] exp_setup3(input logic [3:0] c);
		return 32'h8000_0080 | {28'h0, c[3], 2'b00, c[0]};
	endfunction

	// verdict and end of run
	task automatic stop_test;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// compare a bus read
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// compare a sideband output
	task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// wait for hready high at a rising edge; only the watchdog ends a stuck wait
	task automatic wait_rdy;
		do
			@(posedge i_mclk);
		while (o_hreadyout !== 1'b1);
	endtask

	// one single ahb-lite transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= {20'h0, a};
		i_hwrite <= wr;
		i_hsize <= 3'h2;
		wait_rdy();
		i_hsel <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_rdy();
		rd = o_hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_rd(rd, exp);
	endtask

	// let registered outputs follow the last write; read before the edge's updates land
	task automatic settle;
		repeat (2) @(posedge i_mclk);
	endtask

	// watchdog: the sequence needs a few thousand cycles at most
	initial
	begin
		#200000;
		mismatches++;
		stop_test();
	end

	// main sequence
	initial
	begin
		repeat (5) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		// defaults, plus an unmapped word that must read zero
		foreach (offs[i])
			rdc(offs[i], NBT_RST_VAL);
		// random translated bases, reserved nibble never sticks
		repeat (4)
		begin
			v = xs();
			wr(NBT_OFF_BAR2_TBASE, v);
			rdc(NBT_OFF_BAR2_TBASE, v & 32'hffff_fff0);
			tb2 = v & 32'hffff_fff0;
		end
		tb1 = xs() & 32'hffff_fff0;
		wr(NBT_OFF_BAR1_TBASE, tb1);
		// bar2 32-bit memory, size 7, with every reserved bit set in the write
		wr(NBT_OFF_BAR2_SETUP, 32'hffff_fc70);
		rdc(NBT_OFF_BAR2_SETUP, 32'h8000_0070);
		settle();
		chk_out({63'h0, o_bar2_pair64}, 64'h0);
		chk_out(o_bar2_xlat_base, {32'h0, tb2});
		// every space, type and prefetch code of bar3, size 8
		for (int c = 0; c < 16; c++)
		begin
			wr(NBT_OFF_BAR3_SETUP, 32'h8000_0080 | c);
			rdc(NBT_OFF_BAR3_SETUP, exp_setup3(c[3:0]));
			wr(NBT_OFF_BAR3_BASE, 32'hffff_ffff);
			rdc(NBT_OFF_BAR3_BASE, 32'hffff_ff00 | (c & 32'h9));
		end
		settle();
		chk_out({32'h0, o_bar3_base}, {32'h0, 32'hffff_ff00});
		// disabled bar3, then a size below four
		wr(NBT_OFF_BAR3_SETUP, 32'h0000_0080);
		rdc(NBT_OFF_BAR3_BASE, 32'h0);
		wr(NBT_OFF_BAR3_SETUP, 32'h8000_0030);
		wr(NBT_OFF_BAR3_BASE, 32'hffff_ffff);
		rdc(NBT_OFF_BAR3_BASE, 32'h0);
		wr(NBT_OFF_BAR3_SETUP, 32'h8000_0081);
		// bar2 base with size 7, then bar2 disabled
		wr(NBT_OFF_BAR2_BASE, 32'hffff_ffff);
		rdc(NBT_OFF_BAR2_BASE, 32'hffff_ff80);
		wr(NBT_OFF_BAR2_SETUP, 32'h0000_0070);
		rdc(NBT_OFF_BAR2_BASE, 32'h0);
		settle();
		chk_out(o_bar2_base, 64'h0);
		// bar2 enabled with a size below four: base stays read-only zero
		wr(NBT_OFF_BAR2_SETUP, 32'h8000_0020);
		wr(NBT_OFF_BAR2_BASE, 32'hffff_ffff);
		rdc(NBT_OFF_BAR2_BASE, 32'h0);
		settle();
		chk_out(o_bar2_base, 64'h0);
		// 64-bit memory pairing: bar3 becomes bar2 upper half
		wr(NBT_OFF_BAR2_SETUP, 32'h8000_0074);
		b3 = xs();
		wr(NBT_OFF_BAR3_BASE, b3);
		rdc(NBT_OFF_BAR3_BASE, b3);
		rdc(NBT_OFF_BAR3_SETUP, 32'h0);
		wr(NBT_OFF_BAR3_SETUP, 32'h8000_03ff);
		rdc(NBT_OFF_BAR3_SETUP, 32'h0);
		settle();
		chk_out({63'h0, o_bar2_pair64}, 64'h1);
		chk_out({32'h0, o_bar2_base[63:32]}, {32'h0, b3});
		chk_out({32'h0, o_bar3_base}, 64'h0);
		chk_out(o_bar2_xlat_base, {tb1, tb2});
		// the modelled reset brings back defaults
		i_rst <= 1'b1;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		rdc(NBT_OFF_BAR2_SETUP, NBT_RST_VAL);
		rdc(NBT_OFF_BAR2_TBASE, NBT_RST_VAL);
		stop_test();
	end
endmodule
`default_nettype wire
